// file: verilog/mmso_core.sv
// Execute unit for copy, multiply, negate, no-operation, pop and push.
// Assumes an Avalon-MM master feeds instruction words and reads the state.
//
// Behaviour
// (RULE_01) Copy accumulator into addressed file register.
// (RULE_02) Offset in 256-byte bank; a picks bank.
// (RULE_03) a=0, extended, offset<=95: indexed addressing.
// (RULE_04) Literal multiply into 16-bit product pair.
// (RULE_05) Product high byte and low byte split.
// (RULE_06) Multiplies leave all status flags untouched.
// (RULE_07) File multiply keeps both operands unchanged.
// (RULE_08) Negate file register: inverse plus one.
// (RULE_09) Negate updates N, OV, C, DC, Z.
// (RULE_10) Pop discards top of return stack.
// (RULE_11) Push program counter plus two.
// (RULE_12) One word, one cycle of four phases.
// (RULE_13) Zero or 1111-prefixed word is no-operation.
//
// Design decisions made here: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
module mmso_core (
   input  wire logic        sys_clk_i,
   input  wire logic        rst_i,
   input  wire logic [7:0]  avs_address_i,
   input  wire logic        avs_read_i,
   input  wire logic        avs_write_i,
   input  wire logic [31:0] avs_writedata_i,
   input  wire logic [3:0]  avs_byteenable_i,
   output logic      [31:0] avs_readdata_o,
   output logic             avs_waitrequest_o
);
   // ****************************************************************
   // State
   // ****************************************************************
   typedef enum logic [2:0] {ST_IDLE, ST_Q1, ST_Q2, ST_Q3, ST_Q4} mmso_phase_t;

   mmso_phase_t          phase_q;
   logic [15:0]          instr_q;
   logic [7:0]           acc_q;
   logic [3:0]           bsr_q;
   logic                 ext_q;
   logic [11:0]          idx_q;
   mmso_pkg::mmso_flags_t status_q;
   logic [7:0]           prod_hi_q;
   logic [7:0]           prod_lo_q;
   logic [20:0]          pc_q;
   logic [4:0]           sptr_q;
   logic [11:0]          maddr_q;
   logic [11:0]          faddr_q;
   logic [7:0]           opnd_q;
   mmso_pkg::mmso_op_t   op_q;
   logic                 ack_q;
   logic [31:0]          rdata_q;
   logic [7:0]           mem_q [mmso_pkg::MEM_WORDS];
   logic [20:0]          stack_q [mmso_pkg::STACK_DEPTH];

   // ****************************************************************
   // Decode
   // ****************************************************************
   wire logic [7:0]  f_off      = instr_q[7:0];
   wire logic        a_bit      = instr_q[8];
   wire logic        is_copy    = instr_q[15:9] == mmso_pkg::OPC_COPY_ACC_TO_FILE;
   wire logic        is_mul_lit = instr_q[15:8] == mmso_pkg::OPC_MULTIPLY_ACC_LIT;
   wire logic        is_mul_f   = instr_q[15:9] == mmso_pkg::OPC_MULTIPLY_ACC_FILE;
   wire logic        is_neg     = instr_q[15:9] == mmso_pkg::OPC_NEGATE_FILE;
   wire logic        is_pop     = instr_q == mmso_pkg::OPC_POP;
   wire logic        is_push    = instr_q == mmso_pkg::OPC_PUSH;
   wire mmso_pkg::mmso_op_t op_d =
      is_copy    ? mmso_pkg::OP_COPY     :                             // see RULE_01
      is_mul_lit ? mmso_pkg::OP_MUL_LIT  :
      is_mul_f   ? mmso_pkg::OP_MUL_FILE :
      is_neg     ? mmso_pkg::OP_NEG      :
      is_pop     ? mmso_pkg::OP_POP      :
      is_push    ? mmso_pkg::OP_PUSH     : mmso_pkg::OP_NONE;         // see RULE_13

   // File address: bank select, indexed window, or the two halves of the access bank.
   wire logic        use_idx    = !a_bit && ext_q && (f_off <= mmso_pkg::IDX_LIMIT);
   wire logic [11:0] acc_bank   = (f_off < mmso_pkg::ACCESS_SPLIT) ? {4'h0, f_off}
                                  : {mmso_pkg::ACCESS_HIGH_BANK, f_off};
   wire logic [11:0] faddr_d    = a_bit   ? {bsr_q, f_off} :            // see RULE_02
                                  use_idx ? idx_q + {4'h0, f_off} :     // see RULE_03
                                  acc_bank;

   mmso_pkg::mmso_alu_t alu_res;
   mmso_alu u_alu (
      .acc_i  (acc_q),
      .opnd_i (opnd_q),
      .res_o  (alu_res)
   );

   // ****************************************************************
   // Register bus
   // ****************************************************************
   wire logic        busy     = phase_q != ST_IDLE;
   wire logic        req      = avs_read_i || avs_write_i;
   // Requests wait out a running instruction, so software never races the core.
   wire logic        take     = req && !ack_q && !busy;
   wire logic        wr_fire  = avs_write_i && ack_q;
   wire logic [31:0] be_mask  = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                                 {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
   wire logic [20:0] top_of_return_stack      = (sptr_q == 5'h00) ? 21'h000000 : stack_q[sptr_q - 5'h01];
   logic [31:0]      rd_mux;
   always_comb begin
      case (avs_address_i)
         mmso_pkg::REG_INSTR:    rd_mux = {16'h0000, instr_q};
         mmso_pkg::REG_ACC:      rd_mux = {24'h000000, acc_q};
         mmso_pkg::REG_BANK_SEL: rd_mux = {28'h0000000, bsr_q};
         mmso_pkg::REG_CTRL:     rd_mux = {31'h00000000, ext_q};
         mmso_pkg::REG_IDX_BASE: rd_mux = {20'h00000, idx_q};
         mmso_pkg::REG_STATUS:   rd_mux = {23'h000000, busy, 3'h0, status_q};
         mmso_pkg::REG_PRODUCT:  rd_mux = {16'h0000, prod_hi_q, prod_lo_q};
         mmso_pkg::REG_PC:       rd_mux = {11'h000, pc_q};
         mmso_pkg::REG_TOS:      rd_mux = {11'h000, top_of_return_stack};
         mmso_pkg::REG_SPTR:     rd_mux = {27'h0000000, sptr_q};
         mmso_pkg::REG_MEM_ADDR: rd_mux = {20'h00000, maddr_q};
         mmso_pkg::REG_MEM_DATA: rd_mux = {24'h000000, mem_q[maddr_q]};
         default:                rd_mux = 32'h00000000;
      endcase
   end
   wire logic [31:0] wval     = (rd_mux & ~be_mask) | (avs_writedata_i & be_mask);
   wire logic        wr_at    = wr_fire;
   wire logic        wr_instr = wr_at && avs_address_i == mmso_pkg::REG_INSTR;

   assign avs_waitrequest_o = !ack_q;
   assign avs_readdata_o    = rdata_q;

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         ack_q   <= 1'b0;
         rdata_q <= 32'h00000000;
      end else begin
         ack_q <= take;
         if (take) begin
            rdata_q <= rd_mux;
         end
      end
   end

   // ****************************************************************
   // Phase sequencer
   // ****************************************************************
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         phase_q <= ST_IDLE;
         op_q    <= mmso_pkg::OP_NONE;
         faddr_q <= 12'h000;
         instr_q <= 16'h0000;
      end else begin
         case (phase_q)
            ST_IDLE: if (wr_instr) begin
               phase_q <= ST_Q1;
               instr_q <= wval[15:0];
            end
            ST_Q1: begin                                               // see RULE_12
               phase_q <= ST_Q2;
               op_q    <= op_d;
               faddr_q <= faddr_d;
            end
            ST_Q2:   phase_q <= ST_Q3;
            ST_Q3:   phase_q <= ST_Q4;
            ST_Q4:   phase_q <= ST_IDLE;
            default: phase_q <= ST_IDLE;
         endcase
      end
   end

   // ****************************************************************
   // Operand read, process and write back
   // ****************************************************************
   wire logic q2 = phase_q == ST_Q2;
   wire logic q3 = phase_q == ST_Q3;
   wire logic q4 = phase_q == ST_Q4;
   wire logic        lit_op   = op_q == mmso_pkg::OP_MUL_LIT;
   wire logic        mul_op   = lit_op || (op_q == mmso_pkg::OP_MUL_FILE);
   // The literal multiply takes its operand from the instruction word, the rest from memory.
   wire logic [7:0]  opnd_d   = lit_op ? f_off : mem_q[faddr_q];          // see RULE_04
   wire logic        do_copy  = q4 && (op_q == mmso_pkg::OP_COPY);        // see RULE_01
   wire logic        do_mul   = q4 && mul_op;                             // see RULE_04
   wire logic        do_neg   = q4 && (op_q == mmso_pkg::OP_NEG);         // see RULE_08
   wire logic        do_push  = q2 && (op_q == mmso_pkg::OP_PUSH);        // see RULE_11
   wire logic        do_pop   = q3 && (op_q == mmso_pkg::OP_POP);         // see RULE_10
   // A push onto a full stack or a pop from an empty one leaves the stack untouched,
   // so software must keep its own depth within the stack's size.
   wire logic        push_ok  = do_push && (sptr_q != mmso_pkg::SPTR_MAX);
   wire logic        pop_ok   = do_pop && (sptr_q != 5'h00);
   wire logic [20:0] pc_next  = pc_q + mmso_pkg::PC_STEP;                 // see RULE_11

   wire logic        wr_acc   = wr_at && (avs_address_i == mmso_pkg::REG_ACC);
   wire logic        wr_bsr   = wr_at && (avs_address_i == mmso_pkg::REG_BANK_SEL);
   wire logic        wr_ctrl  = wr_at && (avs_address_i == mmso_pkg::REG_CTRL);
   wire logic        wr_idx   = wr_at && (avs_address_i == mmso_pkg::REG_IDX_BASE);
   wire logic        wr_prod  = wr_at && (avs_address_i == mmso_pkg::REG_PRODUCT);
   wire logic        wr_pc    = wr_at && (avs_address_i == mmso_pkg::REG_PC);
   wire logic        wr_sptr  = wr_at && (avs_address_i == mmso_pkg::REG_SPTR);
   wire logic        wr_maddr = wr_at && (avs_address_i == mmso_pkg::REG_MEM_ADDR);
   wire logic        wr_mdata = wr_at && (avs_address_i == mmso_pkg::REG_MEM_DATA);

   // Copy and negate own the memory port in phase four; the bus reaches it only while idle.
   // A file multiply never writes it, so both of its operands survive.
   wire logic        exec_wr  = do_copy || do_neg;
   wire logic        mem_we   = exec_wr || wr_mdata;                      // see RULE_07
   wire logic [11:0] mem_wa   = exec_wr ? faddr_q : maddr_q;
   wire logic [7:0]  mem_wd   = do_neg ? alu_res.neg : do_copy ? acc_q : wval[7:0];
   wire logic [15:0] prod_d   = wr_prod ? wval[15:0] : alu_res.product;
   wire logic [4:0]  sptr_d   = wr_sptr ? wval[4:0]
                                : push_ok ? sptr_q + 5'h01 : sptr_q - 5'h01;

   // ****************************************************************
   // Registers
   // ****************************************************************
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         acc_q   <= mmso_pkg::ACC_RST;
         bsr_q   <= mmso_pkg::BSR_RST;
         ext_q   <= mmso_pkg::EXT_RST;
         idx_q   <= mmso_pkg::IDX_RST;
         maddr_q <= mmso_pkg::MADDR_RST;
      end else begin
         if (wr_acc) begin
            acc_q <= wval[7:0];
         end
         if (wr_bsr) begin
            bsr_q <= wval[3:0];
         end
         if (wr_ctrl) begin
            ext_q <= wval[mmso_pkg::CTRL_EXT_BIT];
         end
         if (wr_idx) begin
            idx_q <= wval[11:0];
         end
         if (wr_maddr) begin
            maddr_q <= wval[11:0];
         end
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         opnd_q   <= mmso_pkg::OPND_RST;
         status_q <= mmso_pkg::STATUS_RST;
      end else begin
         if (q2) begin
            opnd_q <= opnd_d;
         end
         // Only the negate writes the flags, so a zero product leaves Z as it was.
         if (do_neg) begin                                                // see RULE_06
            status_q <= alu_res.flags;                                    // see RULE_09
         end
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         prod_hi_q <= mmso_pkg::PROD_RST[15:8];
         prod_lo_q <= mmso_pkg::PROD_RST[7:0];
      end else begin
         if (do_mul || wr_prod) begin
            prod_hi_q <= prod_d[15:8];                                    // see RULE_05
            prod_lo_q <= prod_d[7:0];
         end
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         pc_q   <= mmso_pkg::PC_RST;
         sptr_q <= mmso_pkg::SPTR_RST;
      end else begin
         if (wr_pc) begin
            pc_q <= wval[20:0];
         end else if (q4) begin
            pc_q <= pc_next;                                              // see RULE_12
         end
         if (wr_sptr || push_ok || pop_ok) begin
            sptr_q <= sptr_d;                                             // see RULE_10
         end
      end
   end

   // The arrays have no reset; software loads the locations it uses before it runs code.
   always_ff @(posedge sys_clk_i) begin
      if (mem_we) begin
         mem_q[mem_wa] <= mem_wd;                                         // see RULE_01
      end
      if (push_ok) begin
         stack_q[sptr_q] <= pc_next;                                      // see RULE_11
      end
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   chk_phase_order: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see RULE_12
      phase_q == ST_Q1 |=> phase_q == ST_Q2 ##1 phase_q == ST_Q3 ##1 phase_q == ST_Q4
         ##1 phase_q == ST_IDLE)
      else $error("Instruction cycle left its four phases.");
   chk_pc_advance: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see RULE_12
      q4 |=> pc_q == $past(pc_q) + mmso_pkg::PC_STEP)
      else $error("Program counter did not advance by one word.");
   chk_bank_addr: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see RULE_02
      (phase_q == ST_Q1) && a_bit |=> faddr_q == {$past(bsr_q), $past(f_off)})
      else $error("Banked file address is wrong.");
   chk_prod_value: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see RULE_05
      do_mul |=> {prod_hi_q, prod_lo_q} == {8'h00, $past(acc_q)} * {8'h00, $past(opnd_q)})
      else $error("Product pair does not hold the unsigned product.");
   chk_mul_flags: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see RULE_06
      do_mul |=> $stable(status_q))
      else $error("Multiply changed the status flags.");
   chk_neg_sum: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see RULE_08
      do_neg |-> 8'(alu_res.neg + opnd_q) == 8'h00)
      else $error("Negate result plus operand is not zero.");
   chk_neg_zero_carry: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see RULE_09
      do_neg |=> (status_q.z == ($past(opnd_q) == 8'h00))
         && (status_q.c == ($past(opnd_q) == 8'h00)))
      else $error("Negate zero or carry flag is wrong.");
   chk_push_tos: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see RULE_11
      push_ok |=> top_of_return_stack == $past(pc_q) + mmso_pkg::PC_STEP)
      else $error("Push did not place the next word address on top.");
   chk_pop_depth: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see RULE_10
      pop_ok |=> sptr_q == $past(sptr_q) - 5'h01)
      else $error("Pop did not drop one stack level.");
   chk_nop_quiet: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see RULE_13
      (q4 && op_q == mmso_pkg::OP_NONE) |=> $stable(status_q) && $stable(sptr_q)
         && $stable(prod_hi_q) && $stable(prod_lo_q))
      else $error("No-operation changed core state.");

   cov_neg_of_zero: cover property (@(posedge sys_clk_i) do_neg && (opnd_q == 8'h00));
   cov_mul_file:    cover property (@(posedge sys_clk_i) do_mul && !lit_op);
   cov_idx_mode:    cover property (@(posedge sys_clk_i) (phase_q == ST_Q1) && use_idx);
   cov_pop_stack:   cover property (@(posedge sys_clk_i) pop_ok);
endmodule : mmso_core

// file: verilog/mmso_pkg.sv
// Constants, types and register map of the move, multiply and stack execute unit.
// Assumes a single 40 MHz clock and an Avalon-MM master that issues instructions.
package mmso_pkg;

   // ****************************************************************
   // Register map, byte addresses of aligned 32-bit words
   // ****************************************************************
   localparam logic [7:0] REG_INSTR    = 8'h00;
   localparam logic [7:0] REG_ACC      = 8'h04;
   localparam logic [7:0] REG_BANK_SEL = 8'h08;
   localparam logic [7:0] REG_CTRL     = 8'h0c;
   localparam logic [7:0] REG_IDX_BASE = 8'h10;
   localparam logic [7:0] REG_STATUS   = 8'h14;
   localparam logic [7:0] REG_PRODUCT  = 8'h18;
   localparam logic [7:0] REG_PC       = 8'h1c;
   localparam logic [7:0] REG_TOS      = 8'h20;
   localparam logic [7:0] REG_SPTR     = 8'h24;
   localparam logic [7:0] REG_MEM_ADDR = 8'h28;
   localparam logic [7:0] REG_MEM_DATA = 8'h2c;

   // ****************************************************************
   // Field positions and reset values
   // ****************************************************************
   localparam int CTRL_EXT_BIT    = 0;
   localparam int STATUS_BUSY_BIT = 8;
   localparam logic [7:0]  ACC_RST  = 8'h00;
   localparam logic [3:0]  BSR_RST  = 4'h0;
   localparam logic [11:0] IDX_RST  = 12'h000;
   localparam logic [20:0] PC_RST   = 21'h000000;
   localparam logic [15:0] PROD_RST = 16'h0000;
   localparam logic        EXT_RST   = 1'h0;
   localparam logic [4:0]  SPTR_RST  = 5'h00;
   localparam logic [7:0]  OPND_RST  = 8'h00;
   localparam logic [11:0] MADDR_RST = 12'h000;

   // ****************************************************************
   // Opcodes and addressing constants
   // ****************************************************************
   localparam logic [6:0]  OPC_COPY_ACC_TO_FILE   = 7'h37;
   localparam logic [7:0]  OPC_MULTIPLY_ACC_LIT   = 8'h0d;
   localparam logic [6:0]  OPC_MULTIPLY_ACC_FILE  = 7'h01;
   localparam logic [6:0]  OPC_NEGATE_FILE        = 7'h36;
   localparam logic [15:0] OPC_POP                = 16'h0006;
   localparam logic [15:0] OPC_PUSH               = 16'h0005;
   localparam logic [15:0] OPC_NOP                = 16'h0000;
   localparam logic [3:0]  OPC_NOP_HIGH           = 4'hf;
   localparam logic [7:0]  IDX_LIMIT              = 8'h5f;
   localparam logic [7:0]  ACCESS_SPLIT           = 8'h60;
   localparam logic [3:0]  ACCESS_HIGH_BANK       = 4'hf;
   localparam logic [20:0] PC_STEP                = 21'h000002;
   localparam int          STACK_DEPTH            = 31;
   localparam logic [4:0]  SPTR_MAX               = 5'h1f;
   localparam int          MEM_WORDS              = 4096;

   typedef enum logic [2:0] {
      OP_NONE, OP_COPY, OP_MUL_LIT, OP_MUL_FILE, OP_NEG, OP_POP, OP_PUSH
   } mmso_op_t;

   typedef struct packed {
      logic n;
      logic ov;
      logic z;
      logic dc;
      logic c;
   } mmso_flags_t;

   localparam mmso_flags_t STATUS_RST = 5'h00;

   typedef struct packed {
      logic [15:0] product;
      logic [7:0]  neg;
      mmso_flags_t flags;
   } mmso_alu_t;

endpackage : mmso_pkg

// file: verilog/mmso_alu.sv
// Arithmetic of the execute unit: unsigned 8x8 product and negate with flags.
// Assumes purely combinational use by the sequencer in the same clock domain.
`timescale 1ns/1ps
module mmso_alu (
   input  wire logic [7:0]       acc_i,
   input  wire logic [7:0]       opnd_i,
   output mmso_pkg::mmso_alu_t   res_o
);
   wire logic [8:0] neg_full;
   wire logic [4:0] neg_low;

   // Negation is built as the inverse plus one, so carries fall out directly.
   assign neg_full = {1'b0, ~opnd_i} + 9'h001;                        // see RULE_08
   assign neg_low  = {1'b0, ~opnd_i[3:0]} + 5'h01;

   assign res_o.product  = {8'h00, acc_i} * {8'h00, opnd_i};         // see RULE_04
   assign res_o.neg      = neg_full[7:0];
   assign res_o.flags.n  = neg_full[7];                              // see RULE_09
   assign res_o.flags.ov = (opnd_i == 8'h80);
   assign res_o.flags.z  = (neg_full[7:0] == 8'h00);
   assign res_o.flags.dc = neg_low[4];
   assign res_o.flags.c  = neg_full[8];
endmodule : mmso_alu

// file: sim/test_move_multiply_stack_ops.sv
// Self-checking bench for the move, multiply and stack execute unit.
// Assumes the Avalon-MM register map of the package and a 40 MHz clock.
`timescale 1ns/1ps
module test_move_multiply_stack_ops;
   // ****************************************************************
   // Signals and design
   // ****************************************************************
   logic        sys_clk_i;
   logic        rst_i;
   logic        avs_read_i;
   logic        avs_write_i;
   logic        avs_waitrequest_o;
   logic [7:0]  avs_address_i;
   logic [31:0] avs_writedata_i;
   logic [31:0] avs_readdata_o;
   logic [3:0]  avs_byteenable_i;
   logic [31:0] q;
   int          bad_count;
   int          comparisons;
   logic [7:0]  neg_in [3]  = '{8'h3a, 8'h00, 8'h80};
   logic [7:0]  neg_out [3] = '{8'hc6, 8'h00, 8'h80};
   logic [4:0]  neg_fl [3]  = '{5'h10, 5'h07, 5'h1a};

   mmso_core u_mmso_core (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
      .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
      .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
      .avs_waitrequest_o(avs_waitrequest_o));

   initial begin
      sys_clk_i = 1'b0;
      forever #12.5 sys_clk_i = ~sys_clk_i;
   end

   // ****************************************************************
   // Tasks
   // ****************************************************************
   task automatic summarize();
      $display("Mismatches %0d of %0d comparisons", bad_count, comparisons);
      if (bad_count == 0 && comparisons > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : summarize

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask : check

   // The request stays up until waitrequest is seen low at a rising edge.
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge sys_clk_i);
      avs_address_i   <= a;
      avs_writedata_i <= d;
      avs_write_i     <= wr;
      avs_read_i      <= ~wr;
      do begin
         @(posedge sys_clk_i);
         n++;
      end while (avs_waitrequest_o !== 1'b0 && n < 500);
      q = avs_readdata_o;
      avs_read_i  <= 1'b0;
      avs_write_i <= 1'b0;
      if (n >= 500) begin
         bad_count++;
         summarize();
      end
   endtask : bus

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      check(q, exp);
   endtask : rd_chk

   task automatic flags_chk(input logic [4:0] exp);
      bus(1'b0, mmso_pkg::REG_STATUS, 32'h0);
      check({27'h0, q[4:0]}, {27'h0, exp});
   endtask : flags_chk

   task automatic mem_set(input logic [11:0] a, input logic [7:0] d);
      bus(1'b1, mmso_pkg::REG_MEM_ADDR, {20'h0, a});
      bus(1'b1, mmso_pkg::REG_MEM_DATA, {24'h0, d});
   endtask : mem_set

   task automatic mem_chk(input logic [11:0] a, input logic [7:0] exp);
      bus(1'b1, mmso_pkg::REG_MEM_ADDR, {20'h0, a});
      rd_chk(mmso_pkg::REG_MEM_DATA, {24'h0, exp});
   endtask : mem_chk

   // Polling busy keeps the bench free of any assumed execute latency.
   task automatic exec(input logic [15:0] op);
      int n;
      n = 0;
      bus(1'b1, mmso_pkg::REG_INSTR, {16'h0, op});
      do begin
         bus(1'b0, mmso_pkg::REG_STATUS, 32'h0);
         n++;
      end while (q[mmso_pkg::STATUS_BUSY_BIT] !== 1'b0 && n < 50);
      if (n >= 50) begin
         bad_count++;
         summarize();
      end
   endtask : exec

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   initial begin
      {avs_read_i, avs_write_i, avs_address_i, avs_writedata_i} = '0;
      avs_byteenable_i = 4'hf;
      bad_count = 0;
      comparisons = 0;
      rst_i = 1'b1;
      repeat (4) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      rd_chk(mmso_pkg::REG_PC, 32'h0);
      bus(1'b1, mmso_pkg::REG_ACC, 32'h4f);
      bus(1'b1, mmso_pkg::REG_BANK_SEL, 32'h2);
      mem_set(12'h210, 8'hff);
      exec(16'h6f10);
      mem_chk(12'h210, 8'h4f);
      exec(16'h6e80);
      mem_chk(12'hf80, 8'h4f);
      exec(16'h6e10);
      mem_chk(12'h010, 8'h4f);
      bus(1'b1, mmso_pkg::REG_CTRL, 32'h1);
      bus(1'b1, mmso_pkg::REG_IDX_BASE, 32'h300);
      exec(16'h6e5f);
      mem_chk(12'h35f, 8'h4f);
      exec(16'h6e60);
      mem_chk(12'hf60, 8'h4f);
      bus(1'b1, mmso_pkg::REG_CTRL, 32'h0);
      for (int i = 0; i < 3; i++) begin
         mem_set(12'h2a0, neg_in[i]);
         exec(16'h6da0);
         mem_chk(12'h2a0, neg_out[i]);
         flags_chk(neg_fl[i]);
      end
      bus(1'b1, mmso_pkg::REG_ACC, 32'he2);
      exec(16'h0dc4);
      rd_chk(mmso_pkg::REG_PRODUCT, 32'had08);
      rd_chk(mmso_pkg::REG_ACC, 32'he2);
      flags_chk(5'h1a);
      exec(16'h0d00);
      rd_chk(mmso_pkg::REG_PRODUCT, 32'h0);
      flags_chk(5'h1a);
      bus(1'b1, mmso_pkg::REG_ACC, 32'hc4);
      mem_set(12'h2b0, 8'hb5);
      exec(16'h03b0);
      rd_chk(mmso_pkg::REG_PRODUCT, 32'h8a94);
      mem_chk(12'h2b0, 8'hb5);
      rd_chk(mmso_pkg::REG_ACC, 32'hc4);
      flags_chk(5'h1a);
      bus(1'b1, mmso_pkg::REG_PC, 32'h124);
      exec(16'h0000);
      rd_chk(mmso_pkg::REG_PC, 32'h126);
      exec(16'hf123);
      rd_chk(mmso_pkg::REG_PC, 32'h128);
      rd_chk(mmso_pkg::REG_ACC, 32'hc4);
      bus(1'b1, mmso_pkg::REG_PC, 32'h124);
      exec(16'h0005);
      rd_chk(mmso_pkg::REG_TOS, 32'h126);
      exec(16'h0005);
      rd_chk(mmso_pkg::REG_TOS, 32'h128);
      exec(16'h0006);
      rd_chk(mmso_pkg::REG_TOS, 32'h126);
      summarize();
   end
endmodule : test_move_multiply_stack_ops
